// file: rdm_pkg.sv
// Package for the registered SDRAM module pin interface.
// Shared by the module end and the controller end; no timescale here.
package rdm_pkg;
  localparam int DATA_W   = 64;
  localparam int CHECK_W  = 8;
  localparam int BEAT_W   = DATA_W + CHECK_W;
  localparam int LANES    = 8;
  localparam int LANE_W   = BEAT_W / LANES;
  localparam int ADDR_W   = 13;
  localparam int BANK_W   = 2;
  localparam int RANKS    = 4;
  localparam int CLK_IN   = 4;
  localparam int STRAP_W  = 3;
  localparam int AP_BIT   = 10;
  localparam int MASK_LAT = 2;
  localparam int NBANKS   = 4;
  localparam int BURST_MAX = 8;
  localparam int PD_DIV   = 8;
  // Command code {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    RDM_CMD_MRS = 3'h0,
    RDM_CMD_REF = 3'h1,
    RDM_CMD_PRE = 3'h2,
    RDM_CMD_ACT = 3'h3,
    RDM_CMD_WR  = 3'h4,
    RDM_CMD_RD  = 3'h5,
    RDM_CMD_BST = 3'h6,
    RDM_CMD_NOP = 3'h7
  } rdm_cmd_e;
  typedef enum logic [1:0] {
    RDM_ST_RUN  = 2'h0,
    RDM_ST_SUSP = 2'h1,
    RDM_ST_PDN  = 2'h3,
    RDM_ST_SREF = 2'h2
  } rdm_state_e;
  localparam logic [7:0] RDM_PD_BASE = 8'h50;
endpackage : rdm_pkg

// file: rdm_if.sv
// Pin-level link between a memory controller and the module.
// Two-way data pins carry input, output and output enable per side; presence data carries only an enable per side.
`timescale 1ns/10ps
interface rdm_if;
  import rdm_pkg::*;
  logic [CLK_IN-1:0]  module_clock_inputs;
  logic               clock_enable;
  logic [RANKS-1:0]   rank_select_n;
  logic               ras_n;
  logic               cas_n;
  logic               we_n;
  logic [LANES-1:0]   lane_mask;
  logic [BANK_W-1:0]  bank_select;
  logic [ADDR_W-1:0]  row_col_address;
  logic               registered_mode_select;
  logic [STRAP_W-1:0] presence_bus_strap;
  logic [BEAT_W-1:0]  host_dq_out;
  logic               host_dq_oe;
  logic [BEAT_W-1:0]  mod_dq_out;
  logic [LANES-1:0]   mod_dq_oe;
  logic [BEAT_W-1:0]  dq_in;
  logic               pd_clk;
  logic               host_pd_oe;
  logic               mod_pd_oe;
  logic               pd_data;
  // Wire level: driven lanes from enables, open-drain presence data
  always_comb begin
    for (int i = 0; i < BEAT_W; i++) begin
      if (mod_dq_oe[i/LANE_W]) begin
        dq_in[i] = mod_dq_out[i];
      end else if (host_dq_oe) begin
        dq_in[i] = host_dq_out[i];
      end else begin
        dq_in[i] = 1'b0;
      end
    end
  end
  assign pd_data = ~(host_pd_oe | mod_pd_oe);
  modport module_end (
    input  module_clock_inputs, clock_enable, rank_select_n, ras_n,
    input  cas_n, we_n, lane_mask, bank_select, row_col_address,
    input  registered_mode_select, presence_bus_strap, dq_in, pd_clk,
    input  pd_data,
    output mod_dq_out, mod_dq_oe, mod_pd_oe
  );
  modport host_end (
    output module_clock_inputs, clock_enable, rank_select_n, ras_n,
    output cas_n, we_n, lane_mask, bank_select, row_col_address,
    output registered_mode_select, presence_bus_strap, host_dq_out,
    output host_dq_oe, pd_clk, host_pd_oe,
    input  dq_in, pd_data
  );
endinterface : rdm_if

// file: rdm_module.sv
// Module end: command decode, registered/buffered capture, clock
// enable power states, lane masking, small bank store, presence slave.
// Assumes the link clock equals clk; pins from the host are synchronous
// except presence clock/data, which are synchronised here.
`timescale 1ns/10ps
module rdm_module
  import rdm_pkg::*;
#(
  parameter int MEM_WORDS = 16
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Link
  rdm_if.module_end   lnk,
  // User side status
  output logic [ADDR_W-1:0] mode_word,
  output logic [NBANKS-1:0] bank_open,
  output logic              power_saving,
  output logic              suspended,
  output logic [7:0]        pd_addr_seen
);
  import rdm_pkg::*;
  localparam int IW = $clog2(MEM_WORDS);

  rdm_state_e state, next_state;
  logic [2:0]          cmd_q;
  logic [RANKS-1:0]    cs_q;
  logic [BANK_W-1:0]   ba_q;
  logic [ADDR_W-1:0]   a_q;
  logic [LANES-1:0]    dm_q;
  logic [ADDR_W-1:0]   next_mode_word;
  logic [NBANKS-1:0]   next_bank_open;
  logic [ADDR_W-1:0]   row [NBANKS];
  logic [BEAT_W-1:0]   rd_word;
  logic [3:0]          rd_left, next_rd_left, wr_left, next_wr_left;
  logic [IW-1:0]       col, next_col;
  logic [LANES-1:0]    mask_d1, mask_d2;
  logic [BEAT_W-1:0]   rd_d1, rd_d2;
  logic                rd_v1, rd_v2;
  logic [2:0]          pdc_s, pdd_s;
  logic [7:0]          pd_sh;
  logic [3:0]          pd_cnt;
  logic                pd_ack;

  // Inputs gated off in power states; captured or passed through
  logic       bufs_on;
  logic [2:0] cmd_in;
  logic [2:0] cmd_eff;
  logic [RANKS-1:0]  cs_eff;
  logic [BANK_W-1:0] ba_eff;
  logic [ADDR_W-1:0] a_eff;
  logic              sel;
  logic              gclk_en;
  assign bufs_on = (state == RDM_ST_RUN) || (state == RDM_ST_SUSP);
  assign cmd_in  = {lnk.ras_n, lnk.cas_n, lnk.we_n};
  // Clock input 0 is assumed in phase with clk; others ignored
  assign gclk_en = bufs_on && lnk.clock_enable;
  always_comb begin
    if (lnk.registered_mode_select) begin
      cmd_eff = cmd_q;
      cs_eff  = cs_q;
      ba_eff  = ba_q;
      a_eff   = a_q;
    end else begin
      cmd_eff = cmd_in;
      cs_eff  = lnk.rank_select_n;
      ba_eff  = lnk.bank_select;
      a_eff   = lnk.row_col_address;
    end
    if (!bufs_on) begin
      cs_eff = '1;
    end
  end
  assign sel = gclk_en && (state == RDM_ST_RUN) && ~&cs_eff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= RDM_CMD_NOP;
      cs_q  <= '1;
      ba_q  <= '0;
      a_q   <= '0;
      dm_q  <= '0;
    end else begin
      cmd_q <= cmd_in;
      cs_q  <= bufs_on ? lnk.rank_select_n : '1;
      ba_q  <= lnk.bank_select;
      a_q   <= lnk.row_col_address;
      dm_q  <= lnk.lane_mask;
    end
  end

  // Power state: clock enable sampled on clk in every state, RUN/SUSP and PDN/SREF alike
  always_comb begin
    next_state = state;
    case (state)
      RDM_ST_RUN: begin
        if (!lnk.clock_enable) begin
          if (rd_left != 0 || wr_left != 0) begin
            next_state = RDM_ST_SUSP;
          end else if (!(&cs_eff) && cmd_eff == RDM_CMD_REF) begin
            next_state = RDM_ST_SREF;
          end else if (bank_open == '0) begin
            next_state = RDM_ST_PDN;
          end else begin
            next_state = RDM_ST_SUSP;
          end
        end
      end
      RDM_ST_SUSP: if (lnk.clock_enable) next_state = RDM_ST_RUN;
      RDM_ST_PDN,
      RDM_ST_SREF: if (lnk.clock_enable) next_state = RDM_ST_RUN;
      default: next_state = RDM_ST_RUN;
    endcase
  end

  // Command execution and burst counters
  logic [LANES-1:0] dm_eff;
  assign dm_eff = lnk.registered_mode_select ? dm_q : lnk.lane_mask;
  always_comb begin
    next_mode_word = mode_word;
    next_bank_open = bank_open;
    next_rd_left   = rd_left;
    next_wr_left   = wr_left;
    next_col       = col;
    if (gclk_en && state == RDM_ST_RUN) begin
      if (rd_left != 0) begin
        next_rd_left = rd_left - 4'h1;
        next_col     = col + 1'b1;
      end
      if (wr_left != 0) begin
        next_wr_left = wr_left - 4'h1;
        next_col     = col + 1'b1;
      end
    end
    if (sel) begin
      case (cmd_eff)
        RDM_CMD_MRS: next_mode_word = a_eff;
        RDM_CMD_ACT: next_bank_open[ba_eff] = 1'b1;
        RDM_CMD_PRE: begin
          if (a_eff[AP_BIT]) next_bank_open = '0;
          else next_bank_open[ba_eff] = 1'b0;
        end
        RDM_CMD_RD, RDM_CMD_WR: begin
          next_col = a_eff[IW-1:0];
          if (cmd_eff == RDM_CMD_RD) begin
            next_rd_left = 4'(BURST_MAX);
            next_wr_left = '0;
          end else begin
            next_wr_left = 4'(BURST_MAX);
            next_rd_left = '0;
          end
          if (a_eff[AP_BIT]) next_bank_open[ba_eff] = 1'b0;
        end
        RDM_CMD_BST: begin
          next_rd_left = '0;
          next_wr_left = '0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= RDM_ST_RUN;
      mode_word <= '0;
      bank_open <= '0;
      rd_left   <= '0;
      wr_left   <= '0;
      col       <= '0;
    end else begin
      state     <= next_state;
      mode_word <= next_mode_word;
      bank_open <= next_bank_open;
      rd_left   <= next_rd_left;
      wr_left   <= next_wr_left;
      col       <= next_col;
    end
  end

  always_ff @(posedge clk) begin
    if (sel && cmd_eff == RDM_CMD_ACT) row[ba_eff] <= a_eff;
  end

  // Per-lane write with mask; read with two-clock mask latency
  // Each lane keeps its own store so no array has two writers
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [MEM_WORDS];
      always_ff @(posedge clk) begin
        if (gclk_en && state == RDM_ST_RUN && wr_left != 0 && !dm_eff[g])
          lane_mem[col] <= lnk.dq_in[g*LANE_W +: LANE_W];
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[col];
      assign lnk.mod_dq_oe[g] = rd_v2 && !mask_d2[g];
    end
  endgenerate
  assign lnk.mod_dq_out = rd_d2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_d1 <= '1;
      mask_d2 <= '1;
      rd_v1   <= 1'b0;
      rd_v2   <= 1'b0;
      rd_d1   <= '0;
      rd_d2   <= '0;
    end else if (gclk_en) begin
      mask_d1 <= dm_eff;
      mask_d2 <= mask_d1;
      rd_v1   <= (state == RDM_ST_RUN) && rd_left != 0;
      rd_v2   <= rd_v1;
      rd_d1   <= rd_word;
      rd_d2   <= rd_d1;
    end
  end

  // Presence slave: address byte compared against straps
  logic pd_rise;
  logic pd_fall;
  logic pd_start;
  logic [7:0] pd_me;
  assign pd_rise = pdc_s[1] & ~pdc_s[2];
  assign pd_fall = ~pdc_s[1] & pdc_s[2];
  // Data falling while clock high frames a byte; own ack is no frame
  assign pd_start = pdc_s[1] & pdd_s[2] & ~pdd_s[1] & ~pd_ack;
  assign pd_me = RDM_PD_BASE | 8'(lnk.presence_bus_strap);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdc_s <= '0;
      pdd_s <= '1;
      pd_sh <= '0;
      pd_cnt <= '0;
      pd_ack <= 1'b0;
      pd_addr_seen <= '0;
    end else begin
      pdc_s <= {pdc_s[1:0], lnk.pd_clk};
      pdd_s <= {pdd_s[1:0], lnk.pd_data};
      if (pd_start) begin
        pd_cnt <= 4'h0;
        pd_ack <= 1'b0;
      end else if (pd_rise && pd_cnt != 4'h9) begin
        pd_sh  <= {pd_sh[6:0], pdd_s[1]};
        pd_cnt <= pd_cnt + 4'h1;
        if (pd_cnt == 4'h7) begin
          pd_addr_seen <= {pd_sh[6:0], pdd_s[1]};
          pd_ack <= ({pd_sh[6:0], 1'b0} >> 1) == (pd_me & 8'h7F);
        end
      end else if (pd_fall && pd_cnt == 4'h9) begin
        // Acknowledge stands through the ninth clock high time
        pd_ack <= 1'b0;
        pd_cnt <= 4'h0;
      end
    end
  end
  assign lnk.mod_pd_oe = pd_ack;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_saving <= 1'b0;
      suspended    <= 1'b0;
    end else begin
      power_saving <= (next_state == RDM_ST_PDN) || (next_state == RDM_ST_SREF);
      suspended    <= next_state == RDM_ST_SUSP;
    end
  end
endmodule : rdm_module

// file: rdm_host.sv
// Controller end: drives commands, masks, data and presence clock.
// Assumes the module end shares clk.
`timescale 1ns/10ps
module rdm_host
  import rdm_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Link
  rdm_if.host_end            lnk,
  // User command port
  input  wire logic          req,
  input  wire rdm_cmd_e      req_cmd,
  input  wire logic [RANKS-1:0]  req_rank_n,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [LANES-1:0]  req_mask,
  input  wire logic [BEAT_W-1:0] req_wdata,
  input  wire logic          req_wdata_en,
  input  wire logic          req_cke,
  input  wire logic          req_regmode,
  input  wire logic [STRAP_W-1:0] req_strap,
  input  wire logic          pd_drive_low,
  output logic [BEAT_W-1:0]  rdata
);
  import rdm_pkg::*;
  logic [BEAT_W-1:0] rd_s1;
  logic [$clog2(PD_DIV)-1:0] div, next_div;
  logic pdc, next_pdc;
  assign next_div = div + 1'b1;
  assign next_pdc = (div == '1) ? ~pdc : pdc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.module_clock_inputs    <= '0;
      lnk.clock_enable           <= 1'b1;
      lnk.rank_select_n          <= '1;
      {lnk.ras_n, lnk.cas_n, lnk.we_n} <= RDM_CMD_NOP;
      lnk.lane_mask              <= '0;
      lnk.bank_select            <= '0;
      lnk.row_col_address        <= '0;
      lnk.registered_mode_select <= 1'b0;
      lnk.presence_bus_strap     <= '0;
      lnk.host_dq_out            <= '0;
      lnk.host_dq_oe             <= 1'b0;
      lnk.host_pd_oe             <= 1'b0;
      lnk.pd_clk                 <= 1'b0;
      div   <= '0;
      pdc   <= 1'b0;
      rd_s1 <= '0;
      rdata <= '0;
    end else begin
      lnk.module_clock_inputs    <= {CLK_IN{~lnk.module_clock_inputs[0]}};
      lnk.clock_enable           <= req_cke;
      lnk.rank_select_n          <= req ? req_rank_n : '1;
      {lnk.ras_n, lnk.cas_n, lnk.we_n} <= req ? req_cmd : RDM_CMD_NOP;
      lnk.lane_mask              <= req_mask;
      lnk.bank_select            <= req_bank;
      lnk.row_col_address        <= req_addr;
      lnk.registered_mode_select <= req_regmode;
      lnk.presence_bus_strap     <= req_strap;
      lnk.host_dq_out            <= req_wdata;
      lnk.host_dq_oe             <= req_wdata_en;
      lnk.host_pd_oe             <= pd_drive_low;
      div        <= next_div;
      pdc        <= next_pdc;
      lnk.pd_clk <= next_pdc;
      rd_s1 <= lnk.dq_in;
      rdata <= rd_s1;
    end
  end
endmodule : rdm_host

// file: rdm_link_checker.sv
// Checker for the module link: watches the shared pins only.
// Instantiated beside the interface in the bench top; one clock domain.
`timescale 1ns/10ps
module rdm_link_checker
  import rdm_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // Command pins
  input wire logic [RANKS-1:0] rank_select_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic             clock_enable,
  input wire logic [LANES-1:0] lane_mask,
  // Data and presence pins
  input wire logic             host_dq_oe,
  input wire logic [LANES-1:0] mod_dq_oe,
  input wire logic             pd_clk,
  input wire logic             mod_pd_oe
);
  import rdm_pkg::*;
  logic       rd_cmd;
  logic [5:0] rd_age;
  logic [5:0] oe_run;
  logic [5:0] pd_hi;
  logic [5:0] pd_age;
  assign rd_cmd = (rank_select_n != 4'hf) && ({ras_n, cas_n, we_n} == 3'h5);
  // Saturating ages and run lengths
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_age <= 6'h3f;
      oe_run <= 6'h00;
      pd_hi  <= 6'h00;
      pd_age <= 6'h3f;
    end else begin
      rd_age <= rd_cmd ? 6'h00 : rd_age + 6'((rd_age != 6'h3f));
      oe_run <= (mod_dq_oe != '0) ? oe_run + 6'((oe_run != 6'h3f)) : 6'h00;
      pd_hi  <= mod_pd_oe ? pd_hi + 6'((pd_hi != 6'h3f)) : 6'h00;
      pd_age <= $changed(pd_clk) ? 6'h00 : pd_age + 6'((pd_age != 6'h3f));
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  mask_hiz_a: assert property ((mod_dq_oe & $past(lane_mask, 2)) == '0)
    else $error("read lane driven while masked");
  rd_answer_a: assert property ((rd_cmd && clock_enable && lane_mask == '0)
    |-> ##[2:8] (mod_dq_oe != '0)) else $error("read gave no data");
  rd_cause_a: assert property ((mod_dq_oe != '0) |-> rd_age <= 6'd15)
    else $error("data driven without a selected read");
  burst_len_a: assert property (oe_run <= 6'd8)
    else $error("read burst longer than eight beats");
  no_clash_a: assert property (!(host_dq_oe && mod_dq_oe != '0))
    else $error("both ends drive the data lines");
  pd_ack_len_a: assert property ($rose(mod_pd_oe) |-> mod_pd_oe [*8])
    else $error("presence acknowledge too short");
  pd_ack_end_a: assert property (pd_hi <= 6'd24)
    else $error("presence line held too long");
  pd_timed_a: assert property ($rose(mod_pd_oe) |-> pd_age <= 6'd7)
    else $error("presence drive not timed by its clock");
endmodule : rdm_link_checker

// file: registered_sdram_module_pins_test.sv
// Bench: controller end and module end joined through the interface.
// Drives the controller user port, judges module status and pins.
`timescale 1ns/10ps
module registered_sdram_module_pins_test;
  import rdm_pkg::*;
  logic clk = 0, rst_n = 0, req = 0, wen = 0, cke = 1, regm = 0, pdl = 0;
  rdm_cmd_e cmd = RDM_CMD_NOP;
  logic [3:0] rank_n = 4'hf;
  logic [1:0] bank = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic [7:0] mask = 8'h00;
  logic [2:0] strap = 3'h5;
  logic [BEAT_W-1:0] wdata = '0, rdata, d;
  logic [12:0] mode_word;
  logic [3:0] bank_open;
  logic [7:0] pd_seen, oe;
  logic psave, susp, ack;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  localparam logic [BEAT_W-1:0] P0 = {8{9'h0a5}}, P1 = {8{9'h15a}};
  always #2.5 clk = ~clk;
  rdm_if lnk_if ();
  rdm_module u_rdm_module (.clk(clk), .rst_n(rst_n), .lnk(lnk_if),
    .mode_word(mode_word), .bank_open(bank_open), .power_saving(psave),
    .suspended(susp), .pd_addr_seen(pd_seen));
  rdm_host u_rdm_host (.clk(clk), .rst_n(rst_n), .lnk(lnk_if), .req(req),
    .req_cmd(cmd), .req_rank_n(rank_n), .req_bank(bank), .req_addr(addr),
    .req_mask(mask), .req_wdata(wdata), .req_wdata_en(wen), .req_cke(cke),
    .req_regmode(regm), .req_strap(strap), .pd_drive_low(pdl),
    .rdata(rdata));
  rdm_link_checker u_chk (.clk(clk), .rst_n(rst_n),
    .rank_select_n(lnk_if.rank_select_n), .ras_n(lnk_if.ras_n),
    .cas_n(lnk_if.cas_n), .we_n(lnk_if.we_n),
    .clock_enable(lnk_if.clock_enable), .lane_mask(lnk_if.lane_mask),
    .host_dq_oe(lnk_if.host_dq_oe), .mod_dq_oe(lnk_if.mod_dq_oe),
    .pd_clk(lnk_if.pd_clk), .mod_pd_oe(lnk_if.mod_pd_oe));
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [BEAT_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input rdm_cmd_e c, input logic [3:0] r,
                       input logic [1:0] b, input logic [12:0] a);
    @(negedge clk);
    req = 1;
    cmd = c;
    rank_n = r;
    bank = b;
    addr = a;
    @(negedge clk);
    req = 0;
    repeat (6) @(negedge clk);
  endtask : issue
  // Cycles from request until the mode word shows the new opcode
  task automatic mode_lat(input logic [12:0] a, output int n);
    n = 0;
    @(negedge clk);
    req = 1;
    cmd = RDM_CMD_MRS;
    rank_n = 4'h7;
    addr = a;
    @(negedge clk);
    req = 0;
    while (mode_word !== a && n < 10) begin
      @(negedge clk);
      n++;
    end
  endtask : mode_lat
  task automatic rd_beat(input logic [7:0] m, input logic [12:0] a);
    int n;
    n = 0;
    mask = m;
    @(negedge clk);
    req = 1;
    cmd = RDM_CMD_RD;
    rank_n = 4'he;
    bank = 2'h0;
    addr = a;
    @(negedge clk);
    req = 0;
    while (lnk_if.mod_dq_oe === 8'h00 && n < 12) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    d = rdata;
    oe = lnk_if.mod_dq_oe;
    repeat (10) @(negedge clk);
    mask = 8'h00;
  endtask : rd_beat
  task automatic pd_byte(input logic [7:0] b);
    @(posedge lnk_if.pd_clk);
    @(negedge clk);
    pdl = 1;
    for (int i = 7; i >= 0; i--) begin
      @(negedge lnk_if.pd_clk);
      @(negedge clk);
      pdl = !b[i];
    end
    @(negedge lnk_if.pd_clk);
    @(negedge clk);
    pdl = 0;
    @(posedge lnk_if.pd_clk);
    repeat (4) @(negedge clk);
    ack = lnk_if.mod_pd_oe;
    @(negedge lnk_if.pd_clk);
    @(negedge clk);
    pdl = 1;
    @(posedge lnk_if.pd_clk);
    repeat (2) @(negedge clk);
    pdl = 0;
  endtask : pd_byte
  task automatic t_mode;
    int nb, nr;
    mode_lat(13'h02a5, nb);
    check(mode_word, 13'h02a5);
    issue(RDM_CMD_MRS, 4'hf, 2'h0, 13'h1555);
    check(mode_word, 13'h02a5);
    regm = 1;
    repeat (3) @(negedge clk);
    mode_lat(13'h0f0f, nr);
    check(BEAT_W'(nr), BEAT_W'(nb + 1));
    regm = 0;
    repeat (3) @(negedge clk);
  endtask : t_mode
  task automatic t_bank;
    issue(RDM_CMD_ACT, 4'he, 2'h2, 13'h1abc);
    check(bank_open, 4'h4);
    issue(RDM_CMD_ACT, 4'hb, 2'h1, 13'h0001);
    check(bank_open, 4'h6);
    issue(RDM_CMD_PRE, 4'he, 2'h2, 13'h0000);
    check(bank_open, 4'h2);
    issue(RDM_CMD_ACT, 4'he, 2'h3, 13'h0000);
    issue(RDM_CMD_PRE, 4'he, 2'h0, 13'h0400);
    check(bank_open, 4'h0);
    issue(RDM_CMD_ACT, 4'hf, 2'h0, 13'h0000);
    check(bank_open, 4'h0);
  endtask : t_bank
  task automatic t_power;
    cke = 0;
    repeat (4) @(negedge clk);
    check(psave, 1'b1);
    issue(RDM_CMD_ACT, 4'he, 2'h1, 13'h0000);
    check(bank_open, 4'h0);
    cke = 1;
    repeat (4) @(negedge clk);
    check(psave, 1'b0);
  endtask : t_power
  task automatic t_data;
    issue(RDM_CMD_ACT, 4'he, 2'h0, 13'h0010);
    check(bank_open, 4'h1);
    wdata = P0;
    wen = 1;
    issue(RDM_CMD_WR, 4'he, 2'h0, 13'h0000);
    wdata = P1;
    mask = 8'h01;
    issue(RDM_CMD_WR, 4'he, 2'h0, 13'h0000);
    wen = 0;
    mask = 8'h00;
    repeat (4) @(negedge clk);
    rd_beat(8'h00, 13'h0000);
    check(d, (P1 & ~72'h1ff) | (P0 & 72'h1ff));
    rd_beat(8'h80, 13'h0400);
    check(oe, 8'h7f);
    check(d & {9'h000, {63{1'b1}}}, (P1 & ~72'h1ff | P0 & 72'h1ff) & {9'h000, {63{1'b1}}});
    check(bank_open, 4'h0);
  endtask : t_data
  task automatic t_pd;
    pd_byte(8'haa);
    check(pd_seen, 8'haa);
    check(ack, 1'b1);
    strap = 3'h2;
    pd_byte(8'haa);
    check(ack, 1'b0);
    pd_byte(8'ha4);
    check(ack, 1'b1);
  endtask : t_pd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_mode;
    t_bank;
    t_power;
    t_data;
    t_pd;
    stop_test;
  end
endmodule : registered_sdram_module_pins_test
